// ==== logic/sfb_shell.sv ====
// Purpose: common shell of a special-function block with APB registers
// Assumes: inputs synchronous to pclk
// Notes:   timing advances on the 10 ms tick
//
// Contract
// - set input drives output to one
// - reset overrides all inputs, clears q (scaled_analog_value is not cleared)
// - trigger starts function; count input tallies pulses
// - direction input selects up or down
// - gate low: all other inputs except reset ignored
// - invert input inverts the output
// - reset-all clears every internal value (rtc counters and scaled_analog_value are not cleared)
// - pause input halts the stopwatch
// - unconnected logical inputs read as zero
// - time parameter follows its timebase
// - stopwatch also offers 10 ms timebase
// - clock corrected against reference, bounded drift
// - retentive block keeps state across power loss
// - retentivity option defaults to non-retentive
// - hours, weekly, yearly, PI always retentive
// - protection hides and locks parameters
// - protection covers parameter view, message separately
// - 0..10 V maps to 0..1000, saturates
// - shown value is internal times gain plus offset
// - gain -10.00..+10.00, offset -10000..+10000
`timescale 1ns/100ps
`include "sfb_consts.svh"
module sfb_shell
    import sfb_pkg::*;
#(
    parameter int unsigned TICK_CLKS = `SFB_TICK_NS / `SFB_CLK_NS
)(
    input  logic        pclk,
    input  logic        presetn,
    input  logic [7:0]  paddr,
    input  logic        psel,
    input  logic        penable,
    input  logic        pwrite,
    input  logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic        pready,
    output logic        pslverr,
    input  logic        in_set,
    input  logic        in_rst,
    input  logic        in_trg,
    input  logic        in_cnt,
    input  logic        in_dir,
    input  logic        in_en,
    input  logic        in_inv,
    input  logic        in_ral,
    input  logic        in_lap,
    input  logic [15:0] ain_mv,
    input  logic        ref_pps,
    input  logic        pwr_loss,
    output logic        q,
    output logic [15:0] scaled_analog_value
);

    sfb_ana_if ana ();

    logic [31:0] ctrl_ff;
    logic [15:0] tparam_ff;
    sfb_s16_t    gain_ff;
    sfb_s16_t    offset_ff;
    logic [31:0] prdata_ff;
    logic [31:0] nxt_prdata;
    logic [23:0] pre_ff;
    logic [6:0]  hund_ff;
    logic [5:0]  secm_ff;
    logic [31:0] rtc_sec_ff;
    logic [31:0] rtc_corr_ff;
    logic        pwr_q_ff;
    logic        trg_q_ff;
    logic        cnt_q_ff;
    logic        latch_ff;
    logic        q_ff;
    sfb_tstate_e tstate_ff;
    logic [31:0] remain_ff;
    logic [31:0] count_ff;
    logic [31:0] sw_ff;

    logic [8:0]  live;
    logic        tick10;
    logic        tick_s;
    logic        tick_m;
    logic        unit_tick;
    logic        retain;
    logic        wipe;
    logic        act;
    logic        clear_all;
    logic        trg_rise;
    logic        cnt_rise;
    logic        wr_en;
    logic        addr_ok;
    logic        locked;
    sfb_tb_e     tb;
    sfb_kind_e   kind;

    // time value converted to 10 ms ticks
    function automatic logic [31:0] sfb_ticks(input sfb_tb_e b, input logic [7:0] maj, input logic [7:0] mnr);
        logic [31:0] hs;
        logic [31:0] ms;
        hs = 32'(`SFB_HUND_PER_S);
        ms = 32'(`SFB_S_PER_MIN);
        case (b)
            SFB_TB_M: sfb_ticks = (32'(maj) * ms + 32'(mnr)) * hs;
            SFB_TB_H: sfb_ticks = (32'(maj) * ms + 32'(mnr)) * ms * hs;
            default:  sfb_ticks = 32'(maj) * hs + 32'(mnr);
        endcase
    endfunction : sfb_ticks

    // signed saturation to +/- lim
    function automatic sfb_s16_t sfb_sat(input logic [15:0] v, input logic [15:0] lim);
        logic signed [31:0] sv;
        logic signed [31:0] sl;
        sv = 32'($signed(v));
        sl = $signed({16'h0000, lim});
        if (sv > sl) begin
            sfb_sat = sfb_s16_t'(sl[15:0]);
        end else if (sv < -sl) begin
            sfb_sat = sfb_s16_t'(-lim);
        end else begin
            sfb_sat = sfb_s16_t'(sv[15:0]);
        end
    endfunction : sfb_sat

    // unconnected inputs read low
    assign live = {in_lap, in_ral, in_inv, in_en, in_dir, in_cnt, in_trg, in_rst, in_set}
                  & ctrl_ff[`SFB_CONN_MSB:0];

    assign tb     = sfb_tb_e'(ctrl_ff[`SFB_TB_MSB:`SFB_TB_LSB]);
    assign kind   = sfb_kind_e'(ctrl_ff[`SFB_KIND_MSB:`SFB_KIND_LSB]);
    assign locked = ctrl_ff[`SFB_PROT_BIT] & ~ctrl_ff[`SFB_PROG_BIT];

    // kinds that always retain
    assign retain = ctrl_ff[`SFB_RET_BIT] | (kind == SFB_K_HOURS) | (kind == SFB_K_WEEKLY)
                    | (kind == SFB_K_YEARLY) | (kind == SFB_K_PI);
    assign wipe   = pwr_loss & ~pwr_q_ff & ~retain;
    assign act    = live[`SFB_IN_EN] & ~pwr_loss;
    assign clear_all = live[`SFB_IN_R] | (act & live[`SFB_IN_RAL]) | wipe;
    assign trg_rise  = live[`SFB_IN_TRG] & ~trg_q_ff;
    assign cnt_rise  = live[`SFB_IN_CNT] & ~cnt_q_ff;

    // apb slave, zero wait states
    assign wr_en   = psel & penable & pwrite & addr_ok;
    assign pready  = 1'b1;
    assign pslverr = psel & penable & ~addr_ok;
    assign prdata  = prdata_ff;

    always_comb begin
        addr_ok = (paddr[1:0] == 2'h0) && (paddr <= `SFB_A_RTC_CORR);
    end

    // 10 ms tick, then hundredths and seconds
    assign tick10 = (pre_ff == 24'(TICK_CLKS - 1));
    assign tick_s = tick10 & (hund_ff == `SFB_HUND_PER_S - 7'h01);
    assign tick_m = tick_s & (secm_ff == `SFB_S_PER_MIN - 6'h01);

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pre_ff <= 24'h00_0000;
        end else if (ref_pps || tick10) begin
            pre_ff <= 24'h00_0000;
        end else begin
            pre_ff <= pre_ff + 24'h00_0001;
        end
    end

    // rtc, realigned per reference second
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            hund_ff     <= 7'h00;
            secm_ff     <= 6'h00;
            rtc_sec_ff  <= 32'h0000_0000;
            rtc_corr_ff <= 32'h0000_0000;
        end else if (ref_pps) begin
            hund_ff <= 7'h00;
            secm_ff <= (secm_ff == `SFB_S_PER_MIN - 6'h01) ? 6'h00 : secm_ff + 6'h01;
            if (hund_ff >= `SFB_HALF_S) begin
                rtc_sec_ff <= rtc_sec_ff + 32'h0000_0001;
            end
            if ((hund_ff != 7'h00) || (pre_ff != 24'h00_0000)) begin
                rtc_corr_ff <= rtc_corr_ff + 32'h0000_0001;
            end
        end else if (tick10) begin
            if (tick_s) begin
                hund_ff    <= 7'h00;
                secm_ff    <= tick_m ? 6'h00 : secm_ff + 6'h01;
                rtc_sec_ff <= rtc_sec_ff + 32'h0000_0001;
            end else begin
                hund_ff <= hund_ff + 7'h01;
            end
        end
    end

    // parameter registers
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ctrl_ff   <= `SFB_CTRL_RST;
            tparam_ff <= `SFB_TPARAM_RST;
            gain_ff   <= sfb_s16_t'(`SFB_GAIN_RST);
            offset_ff <= sfb_s16_t'(`SFB_OFFSET_RST);
        end else if (wr_en) begin
            case (paddr)
                `SFB_A_CTRL: begin
                    ctrl_ff <= {14'h0000, pwdata[`SFB_KIND_MSB:0]};
                end
                `SFB_A_TPARAM: begin
                    if (!locked) begin
                        tparam_ff <= pwdata[15:0];
                    end
                end
                `SFB_A_GAIN: begin
                    if (!locked) begin
                        gain_ff <= sfb_sat(pwdata[15:0], `SFB_GAIN_MAX);
                    end
                end
                `SFB_A_OFFSET: begin
                    if (!locked) begin
                        offset_ff <= sfb_sat(pwdata[15:0], `SFB_OFS_MAX);
                    end
                end
                `SFB_A_MSG_T: begin
                    if (!ctrl_ff[`SFB_MPROT_BIT]) begin
                        tparam_ff <= pwdata[15:0];
                    end
                end
                default: begin
                end
            endcase
        end
    end

    // read data captured in the setup cycle
    always_comb begin
        nxt_prdata = 32'h0000_0000;
        case (paddr)
            `SFB_A_CTRL:     nxt_prdata = ctrl_ff;
            `SFB_A_TPARAM:   nxt_prdata = locked ? 32'h0000_0000 : {16'h0000, tparam_ff};
            `SFB_A_GAIN:     nxt_prdata = locked ? 32'h0000_0000 : 32'(gain_ff);
            `SFB_A_OFFSET:   nxt_prdata = locked ? 32'h0000_0000 : 32'(offset_ff);
            `SFB_A_MSG_T:    nxt_prdata = ctrl_ff[`SFB_MPROT_BIT] ? 32'h0000_0000 : {16'h0000, tparam_ff};
            `SFB_A_STATUS:   nxt_prdata = {27'h000_0000, retain, pwr_loss, tstate_ff == SFB_T_DONE,
                                           tstate_ff == SFB_T_RUN, q_ff};
            `SFB_A_COUNT:    nxt_prdata = count_ff;
            `SFB_A_SWATCH:   nxt_prdata = sw_ff;
            `SFB_A_TREMAIN:  nxt_prdata = remain_ff;
            `SFB_A_ANALOG:   nxt_prdata = 32'(ana.value);
            `SFB_A_RTC_SEC:  nxt_prdata = rtc_sec_ff;
            `SFB_A_RTC_CORR: nxt_prdata = rtc_corr_ff;
            default:         nxt_prdata = 32'h0000_0000;
        endcase
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prdata_ff <= 32'h0000_0000;
        end else if (psel && !penable && !pwrite) begin
            prdata_ff <= nxt_prdata;
        end
    end

    // edge history
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            trg_q_ff <= 1'b0;
            cnt_q_ff <= 1'b0;
            pwr_q_ff <= 1'b0;
        end else begin
            trg_q_ff <= live[`SFB_IN_TRG];
            cnt_q_ff <= live[`SFB_IN_CNT];
            pwr_q_ff <= pwr_loss;
        end
    end

    // set latch
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            latch_ff <= 1'b0;
        end else if (clear_all) begin
            latch_ff <= 1'b0;
        end else if (act && live[`SFB_IN_S]) begin
            latch_ff <= 1'b1;
        end
    end

    // on-delay timer
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            tstate_ff <= SFB_T_IDLE;
            remain_ff <= 32'h0000_0000;
        end else if (clear_all) begin
            tstate_ff <= SFB_T_IDLE;
            remain_ff <= 32'h0000_0000;
        end else if (act && trg_rise) begin
            remain_ff <= sfb_ticks(tb, tparam_ff[15:8], tparam_ff[7:0]);
            tstate_ff <= (tparam_ff == 16'h0000) ? SFB_T_DONE : SFB_T_RUN;
        end else begin
            case (tstate_ff)
                SFB_T_IDLE: begin
                end
                SFB_T_RUN: begin
                    if (act && tick10) begin
                        remain_ff <= remain_ff - 32'h0000_0001;
                        if (remain_ff <= 32'h0000_0001) begin
                            tstate_ff <= SFB_T_DONE;
                        end
                    end
                end
                SFB_T_DONE: begin
                end
                default: begin
                    tstate_ff <= SFB_T_IDLE;
                end
            endcase
        end
    end

    // pulse counter
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            count_ff <= 32'h0000_0000;
        end else if (clear_all) begin
            count_ff <= 32'h0000_0000;
        end else if (act && cnt_rise) begin
            if (live[`SFB_IN_DIR]) begin
                count_ff <= count_ff - 32'h0000_0001;
            end else begin
                count_ff <= count_ff + 32'h0000_0001;
            end
        end
    end

    // stopwatch unit follows the timebase
    always_comb begin
        case (tb)
            SFB_TB_M: unit_tick = tick_s;
            SFB_TB_H: unit_tick = tick_m;
            default:  unit_tick = tick10;
        endcase
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            sw_ff <= 32'h0000_0000;
        end else if (clear_all) begin
            sw_ff <= 32'h0000_0000;
        end else if (act && !live[`SFB_IN_LAP] && unit_tick) begin
            sw_ff <= sw_ff + 32'h0000_0001;
        end
    end

    // output stage
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            q_ff <= 1'b0;
        end else if (clear_all) begin
            q_ff <= 1'b0;
        end else if (act) begin
            q_ff <= (latch_ff | (tstate_ff == SFB_T_DONE)) ^ live[`SFB_IN_INV];
        end
    end

    assign q = q_ff;

    // analog scaling
    assign ana.ain_mv = ain_mv;
    assign ana.gain   = gain_ff;
    assign ana.offset = offset_ff;

    sfb_analog u_analog (
        .pclk    (pclk),
        .presetn (presetn),
        .ana     (ana.eng)
    );

    assign scaled_analog_value = ana.value;
endmodule : sfb_shell

// ==== logic/sfb_consts.svh ====
// Purpose: constants of the block shell
// Assumes: APB byte addresses
// Notes:   definitions only
`ifndef SFB_CONSTS_SVH
`define SFB_CONSTS_SVH

// register byte offsets
`define SFB_A_CTRL      8'h00
`define SFB_A_TPARAM    8'h04
`define SFB_A_GAIN      8'h08
`define SFB_A_OFFSET    8'h0C
`define SFB_A_MSG_T     8'h10
`define SFB_A_STATUS    8'h14
`define SFB_A_COUNT     8'h18
`define SFB_A_SWATCH    8'h1C
`define SFB_A_TREMAIN   8'h20
`define SFB_A_ANALOG    8'h24
`define SFB_A_RTC_SEC   8'h28
`define SFB_A_RTC_CORR  8'h2C

// control word fields
`define SFB_CONN_MSB    8
`define SFB_TB_LSB      9
`define SFB_TB_MSB      10
`define SFB_RET_BIT     11
`define SFB_PROT_BIT    12
`define SFB_MPROT_BIT   13
`define SFB_PROG_BIT    14
`define SFB_KIND_LSB    15
`define SFB_KIND_MSB    17

// logical input positions in the connect mask
`define SFB_IN_S        0
`define SFB_IN_R        1
`define SFB_IN_TRG      2
`define SFB_IN_CNT      3
`define SFB_IN_DIR      4
`define SFB_IN_EN       5
`define SFB_IN_INV      6
`define SFB_IN_RAL      7
`define SFB_IN_LAP      8

// reset values
`define SFB_CTRL_RST    32'h0000_03FF
`define SFB_TPARAM_RST  16'h0000
`define SFB_GAIN_RST    16'h0064
`define SFB_OFFSET_RST  16'h0000

// time base
`define SFB_CLK_NS      10
`define SFB_TICK_NS     10_000_000
`define SFB_HUND_PER_S  7'h64
`define SFB_HALF_S      7'h32
`define SFB_S_PER_MIN   6'h3C

// analog scaling
`define SFB_AIN_FULL_MV 16'h2710
`define SFB_AIN_MAX     16'h03E8
`define SFB_MV_PER_LSB  16'h000A
`define SFB_GAIN_SCALE  100
`define SFB_GAIN_MAX    16'h03E8
`define SFB_OFS_MAX     16'h2710

`endif

// ==== logic/sfb_pkg.sv ====
// Purpose: types of the block shell
// Assumes: nothing
// Notes:   constants live in sfb_consts.svh
package sfb_pkg;

    typedef enum logic [1:0] {
        SFB_TB_10MS = 2'h0,
        SFB_TB_S    = 2'h1,
        SFB_TB_M    = 2'h2,
        SFB_TB_H    = 2'h3
    } sfb_tb_e;

    typedef enum logic [2:0] {
        SFB_K_GENERIC = 3'h0,
        SFB_K_HOURS   = 3'h1,
        SFB_K_WEEKLY  = 3'h2,
        SFB_K_YEARLY  = 3'h3,
        SFB_K_PI      = 3'h4
    } sfb_kind_e;

    typedef enum logic [2:0] {
        SFB_T_IDLE = 3'h1,
        SFB_T_RUN  = 3'h2,
        SFB_T_DONE = 3'h4
    } sfb_tstate_e;

    typedef logic signed [15:0] sfb_s16_t;

endpackage : sfb_pkg

// ==== logic/sfb_ana_if.sv ====
// Purpose: analog link between shell and scaler
// Assumes: all signals synchronous to pclk
// Notes:   none
`timescale 1ns/100ps
interface sfb_ana_if
    import sfb_pkg::*;
();
    logic     [15:0] ain_mv;
    sfb_s16_t        gain;
    sfb_s16_t        offset;
    sfb_s16_t        value;

    modport ctl (output ain_mv, output gain, output offset, input value);
    modport eng (input ain_mv, input gain, input offset, output value);
endinterface : sfb_ana_if

// ==== logic/sfb_analog.sv ====
// Purpose: analog scaling, gain and offset
// Assumes: gain in hundredths, both clamped
// Notes:   result one cycle behind inputs
`timescale 1ns/100ps
module sfb_analog
    import sfb_pkg::*;
(
    input  logic  pclk,
    input  logic  presetn,
    sfb_ana_if.eng ana
);
    `include "sfb_consts.svh"

    logic        [15:0] internal;
    logic signed [31:0] prod;
    logic signed [31:0] scaled;
    logic signed [31:0] sum;
    sfb_s16_t           value_ff;

    always_comb begin
        // saturates above full scale
        if (ana.ain_mv >= `SFB_AIN_FULL_MV) begin
            internal = `SFB_AIN_MAX;
        end else begin
            internal = ana.ain_mv / `SFB_MV_PER_LSB;
        end
        prod   = $signed({16'h0000, internal}) * 32'(ana.gain);
        scaled = prod / `SFB_GAIN_SCALE;
        sum    = scaled + 32'(ana.offset);
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            value_ff <= 16'sh0000;
        end else begin
            value_ff <= sfb_s16_t'(sum[15:0]);
        end
    end

    assign ana.value = value_ff;
endmodule : sfb_analog

// ==== test/sfb_shell_props.sv ====
// Purpose: port-level assertions for sfb_shell
// Assumes: one pclk domain
// Notes:   bound to every sfb_shell instance
`timescale 1ns/100ps
module sfb_shell_props #(
    parameter int unsigned TICK_CLKS = 4
)(
    input logic       pclk,
    input logic       presetn,
    input logic [7:0] paddr,
    input logic       psel,
    input logic       penable,
    input logic       pslverr,
    input logic       in_set,
    input logic       in_rst,
    input logic       in_trg,
    input logic       in_en,
    input logic       in_inv,
    input logic       in_ral,
    input logic       pwr_loss,
    input logic       q
);
    default clocking dcb @(posedge pclk); endclocking
    default disable iff (!presetn);

    property p_set_q;
        (in_en && in_set && !in_inv && !in_rst && !in_ral && !pwr_loss) [*3] |-> q;
    endproperty
    a_set_q: assert property (p_set_q) else $error("set did not raise q");
    property p_inv_q;
        (in_en && in_set && in_inv && !in_rst && !in_ral && !pwr_loss && $stable(in_inv)) [*3] |-> !q;
    endproperty
    a_inv_q: assert property (p_inv_q) else $error("invert not applied");
    property p_rst_q;
        in_rst |=> !q;
    endproperty
    a_rst_q: assert property (p_rst_q) else $error("reset did not clear q");
    property p_en_hold;
        (!in_en && !in_rst && !pwr_loss) [*3] |=> $stable(q);
    endproperty
    a_en_hold: assert property (p_en_hold) else $error("q moved while gated");
    property p_ral_q;
        (in_ral && in_en && !in_set && !in_trg && !in_inv && !pwr_loss) [*2] |=> !q;
    endproperty
    a_ral_q: assert property (p_ral_q) else $error("reset-all left q set");
    property p_pwr_hold;
        (pwr_loss && !in_rst) [*3] |=> $stable(q);
    endproperty
    a_pwr_hold: assert property (p_pwr_hold) else $error("q moved during power loss");
    property p_err_map;
        psel && penable |-> pslverr == (paddr > 8'h2C || paddr[1:0] != 2'b00);
    endproperty
    a_err_map: assert property (p_err_map) else $error("pslverr wrong in access");
    property p_err_idle;
        !(psel && penable) |-> !pslverr;
    endproperty
    a_err_idle: assert property (p_err_idle) else $error("pslverr outside access");
endmodule : sfb_shell_props

bind sfb_shell sfb_shell_props #(.TICK_CLKS(TICK_CLKS)) i_props (
    .pclk(pclk), .presetn(presetn), .paddr(paddr), .psel(psel), .penable(penable), .pslverr(pslverr),
    .in_set(in_set), .in_rst(in_rst), .in_trg(in_trg), .in_en(in_en), .in_inv(in_inv), .in_ral(in_ral),
    .pwr_loss(pwr_loss), .q(q)
);

// ==== test/sfb_pps_model.sv ====
// Purpose: reference second source
// Assumes: PERIOD clocks per reference second
// Notes:   one-cycle pulse, free running
`timescale 1ns/100ps
module sfb_pps_model #(
    parameter int unsigned PERIOD = 400
)(
    input  logic pclk,
    input  logic presetn,
    output logic ref_pps
);
    int unsigned cnt_ff;
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            cnt_ff  <= 0;
            ref_pps <= 1'b0;
        end else begin
            ref_pps <= (cnt_ff == PERIOD - 2);
            cnt_ff  <= (cnt_ff == PERIOD - 1) ? 0 : cnt_ff + 1;
        end
    end
endmodule : sfb_pps_model

// ==== test/test_sfb_shell.sv ====
// Purpose: self-checking bench for sfb_shell
// Assumes: TICK_CLKS shortened to 4
// Notes:   analog cases from a table
`timescale 1ns/100ps
`include "sfb_consts.svh"
module test_sfb_shell;
    localparam int unsigned TICKS = 4;
    typedef struct packed {logic [15:0] gain; logic [15:0] ofs; logic [15:0] mv; logic [15:0] res;} sfb_row_s;
    logic        pclk     = 1'b0;
    logic        presetn  = 1'b0;
    logic        psel     = 1'b0;
    logic        penable  = 1'b0;
    logic        pwrite   = 1'b0;
    logic        pwr_loss = 1'b0;
    logic [7:0]  paddr    = 8'h00;
    logic [31:0] pwdata   = 32'h0000_0000;
    logic [8:0]  li       = 9'h000;
    logic [15:0] ain_mv   = 16'h0000;
    logic [31:0] prdata, rdv, v1;
    logic        pready, pslverr, q, ref_pps, erv;
    logic [15:0] sav;
    int          fail_count = 0;
    int          n_checks   = 0;
    int          cyc_cnt    = 0;
    int          n, e;
    sfb_row_s    rows [14] = '{
        '{16'h000A, 16'hFFE2, 16'h0000, 16'hFFE2}, '{16'h000A, 16'hFFE2, 16'h0BB8, 16'h0000},
        '{16'h000A, 16'hFFE2, 16'h2710, 16'h0046}, '{16'h0190, 16'h03E8, 16'h1A5E, 16'h0E74},
        '{16'h03E8, 16'hD8F0, 16'h2710, 16'h0000}, '{16'h0001, 16'h0005, 16'h1388, 16'h000A},
        '{16'h000A, 16'h0000, 16'h0014, 16'h0000}, '{16'h03E8, 16'h0000, 16'h0014, 16'h0014},
        '{16'h0064, 16'h0000, 16'h2EE0, 16'h03E8}, '{16'h07D0, 16'h0000, 16'h2710, 16'h2710},
        '{16'hFC18, 16'h0000, 16'h1388, 16'hEC78}, '{16'hFFF6, 16'h0000, 16'h0032, 16'h0000},
        '{16'h0064, 16'h4E20, 16'h0000, 16'h2710}, '{16'h0064, 16'hFF38, 16'h1388, 16'h012C}};
    logic [31:0] t_ctl [4] = '{32'h0000_03FF, 32'h0000_05FF, 32'h0000_01FF, 32'h0000_07FF};
    logic [31:0] t_par [4] = '{32'h0000_0003, 32'h0000_0001, 32'h0000_0103, 32'h0000_0001};
    int          t_tk  [4] = '{3, 100, 103, 6000};
    logic [31:0] p_ctl [3] = '{32'h0000_03FF, 32'h0000_0BFF, 32'h0000_83FF};
    logic        p_q   [3] = '{1'b0, 1'b1, 1'b1};

    sfb_shell #(.TICK_CLKS(TICKS)) i_dut (
        .pclk(pclk), .presetn(presetn), .paddr(paddr), .psel(psel), .penable(penable), .pwrite(pwrite),
        .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr), .in_set(li[0]), .in_rst(li[1]),
        .in_trg(li[2]), .in_cnt(li[3]), .in_dir(li[4]), .in_en(li[5]), .in_inv(li[6]), .in_ral(li[7]),
        .in_lap(li[8]), .ain_mv(ain_mv), .ref_pps(ref_pps), .pwr_loss(pwr_loss), .q(q),
        .scaled_analog_value(sav)
    );
    sfb_pps_model #(.PERIOD(100 * TICKS)) i_pps (.pclk(pclk), .presetn(presetn), .ref_pps(ref_pps));

    always #5 pclk = ~pclk;
    always @(posedge pclk) if (presetn) cyc_cnt <= cyc_cnt + 1;

    task automatic final_report;
        $display("checks %0d mismatches %0d", n_checks, fail_count);
        if (fail_count == 0 && n_checks > 0) $display("ALL CHECKS OK");
        else $display("CHECKS NOT OK");
        $finish;
    endtask : final_report
    task automatic tmo;
        fail_count++;
        $display("ERROR wait expected done seen timeout");
        final_report();
    endtask : tmo
    task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
        n_checks++;
        if (seen !== exp) begin
            fail_count++;
            $display("ERROR %s expected %h seen %h", nm, exp, seen);
        end
    endtask : chk
    task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] wd,
                       output logic [31:0] rd, output logic err);
        int k;
        k = 0;
        @(posedge pclk);
        psel   <= 1'b1;
        pwrite <= wr;
        paddr  <= a;
        pwdata <= wd;
        @(posedge pclk);
        penable <= 1'b1;
        do begin
            @(posedge pclk);
            k++;
        end while (pready !== 1'b1 && k < 16);
        if (pready !== 1'b1) tmo();
        rd = prdata;
        err = pslverr;
        psel    <= 1'b0;
        penable <= 1'b0;
    endtask : apb
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        apb(1'b1, a, d, rdv, erv);
    endtask : wr
    task automatic rchk(input string nm, input logic [7:0] a, input logic [31:0] exp);
        apb(1'b0, a, 32'h0000_0000, rdv, erv);
        chk(nm, rdv, exp);
    endtask : rchk
    task automatic drv(input logic [8:0] v);
        @(posedge pclk);
        li <= v;
    endtask : drv
    task automatic cyc(input int k);
        repeat (k) @(posedge pclk);
    endtask : cyc
    task automatic qchk(input logic v);
        @(negedge pclk);
        chk("q", {31'h0, q}, {31'h0, v});
    endtask : qchk
    task automatic pulse(input logic [8:0] b, input logic [8:0] p, input int k);
        repeat (k) begin
            drv(b | p);
            drv(b);
        end
    endtask : pulse
    task automatic wait_q(input logic v, input int lim, output int k);
        k = 0;
        while (q !== v && k < lim) begin
            @(negedge pclk);
            k++;
        end
        if (q !== v) tmo();
    endtask : wait_q

    initial begin
        repeat (16) @(posedge pclk);
        presetn <= 1'b1;
        qchk(1'b0);
        rchk("ctrl_rst", `SFB_A_CTRL, 32'h0000_03FF);
        rchk("gain_rst", `SFB_A_GAIN, 32'h0000_0064);
        apb(1'b0, 8'h30, 32'h0000_0000, rdv, erv);
        chk("unmapped_err", {31'h0, erv}, 32'h0000_0001);
        chk("unmapped_data", rdv, 32'h0000_0000);
        $display("reset done");
        foreach (rows[i]) begin
            wr(`SFB_A_GAIN, 32'($signed(rows[i].gain)));
            wr(`SFB_A_OFFSET, 32'($signed(rows[i].ofs)));
            @(posedge pclk);
            ain_mv <= rows[i].mv;
            cyc(3);
            rchk("analog", `SFB_A_ANALOG, 32'($signed(rows[i].res)));
            chk("scaled", {16'h0000, sav}, {16'h0000, rows[i].res});
        end
        $display("analog done");
        drv(9'h021); cyc(3); qchk(1'b1);
        drv(9'h023); cyc(2); qchk(1'b0);
        drv(9'h061); cyc(3); qchk(1'b0);
        drv(9'h021); cyc(3); qchk(1'b1);
        drv(9'h0A0); cyc(3); qchk(1'b0);
        drv(9'h001); cyc(4); qchk(1'b0);
        drv(9'h021); cyc(3); qchk(1'b1);
        drv(9'h040); cyc(3); qchk(1'b1);
        $display("logic done");
        drv(9'h0A0);
        pulse(9'h020, 9'h008, 5);
        pulse(9'h030, 9'h008, 2);
        cyc(2);
        rchk("count", `SFB_A_COUNT, 32'h0000_0003);
        drv(9'h0A0);
        cyc(2);
        rchk("count_ral", `SFB_A_COUNT, 32'h0000_0000);
        wr(`SFB_A_CTRL, 32'h0000_03F3);
        wr(`SFB_A_TPARAM, 32'h0000_0000);
        pulse(9'h020, 9'h00C, 3);
        qchk(1'b0);
        rchk("count_nc", `SFB_A_COUNT, 32'h0000_0000);
        $display("counter done");
        foreach (t_ctl[i]) begin
            drv(9'h0A0);
            wr(`SFB_A_CTRL, t_ctl[i]);
            wr(`SFB_A_TPARAM, t_par[i]);
            pulse(9'h020, 9'h004, 1);
            e = t_tk[i] * TICKS;
            wait_q(1'b1, e + 20, n);
            chk("timer", {31'h0, n + 6 >= e && n <= e + 6}, 32'h0000_0001);
        end
        $display("timer done");
        wr(`SFB_A_CTRL, 32'h0000_03FF);
        drv(9'h020);
        cyc(20);
        drv(9'h120);
        cyc(2);
        apb(1'b0, `SFB_A_SWATCH, 32'h0000_0000, v1, erv);
        cyc(40);
        rchk("lap_hold", `SFB_A_SWATCH, v1);
        drv(9'h020);
        cyc(40);
        apb(1'b0, `SFB_A_SWATCH, 32'h0000_0000, rdv, erv);
        chk("swatch_run", {31'h0, rdv > v1 + 8 && rdv < v1 + 16}, 32'h0000_0001);
        $display("stopwatch done");
        wr(`SFB_A_TPARAM, 32'h0000_0005);
        wr(`SFB_A_CTRL, 32'h0000_13FF);
        wr(`SFB_A_GAIN, 32'h0000_0200);
        rchk("gain_hid", `SFB_A_GAIN, 32'h0000_0000);
        rchk("msg_t", `SFB_A_MSG_T, 32'h0000_0005);
        wr(`SFB_A_CTRL, 32'h0000_53FF);
        rchk("gain_prog", `SFB_A_GAIN, 32'h0000_0064);
        wr(`SFB_A_CTRL, 32'h0000_23FF);
        rchk("msg_hid", `SFB_A_MSG_T, 32'h0000_0000);
        $display("protect done");
        foreach (p_ctl[i]) begin
            wr(`SFB_A_CTRL, p_ctl[i]);
            drv(9'h0A0);
            drv(9'h021);
            cyc(3);
            drv(9'h020);
            pwr_loss <= 1'b1;
            cyc(4);
            pwr_loss <= 1'b0;
            cyc(3);
            qchk(p_q[i]);
        end
        $display("power done");
        e = cyc_cnt / (100 * TICKS);
        apb(1'b0, `SFB_A_RTC_SEC, 32'h0000_0000, rdv, erv);
        chk("rtc", {31'h0, rdv + 1 >= e && rdv <= e + 1}, 32'h0000_0001);
        $display("clock done");
        final_report();
    end
endmodule : test_sfb_shell
